// ===== src/acm_matcher.sv
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module acm_matcher
  import acm_pkg::*;
(
  input  wire logic        clk_i,       // 125 mhz clock
  input  wire logic        rst_i,       // async reset, active high
  // wishbone slave
  input  wire logic        wb_cyc_i,    // bus cycle
  input  wire logic        wb_stb_i,    // strobe
  input  wire logic        wb_we_i,     // write enable
  input  wire logic [4:0]  wb_adr_i,    // byte address
  input  wire logic [3:0]  wb_sel_i,    // byte lanes
  input  wire logic [31:0] wb_dat_i,    // write data
  output logic [31:0]      wb_dat_o,    // read data
  output logic             wb_ack_o,    // acknowledge
  // parsed frame fields from the parser
  input  wire logic        frm_valid_i, // one-cycle header strobe
  input  wire logic        frm_ipv4_i,  // frame is ipv4
  input  wire logic [7:0]  frm_proto_i, // protocol field
  input  wire logic [7:0]  frm_ttl_i,   // time-to-live
  input  wire logic        frm_mf_i,    // more-fragments bit
  input  wire logic [12:0] frm_foff_i,  // fragment offset
  input  wire logic        frm_opt_i,   // options present
  input  wire logic [31:0] frm_src_i,   // source address
  input  wire logic [31:0] frm_dst_i,   // destination address
  // result
  output logic             hit_valid_o, // result strobe
  output logic             hit_o        // entry hit
);
  logic [31:0] ctrl_q;
  logic [31:0] src_addr_q;
  logic [31:0] src_mask_q;
  logic [31:0] dst_addr_q;
  logic [31:0] dst_mask_q;
  logic [15:0] hit_cnt_q;
  logic        ack_d;
  logic [31:0] rdat_d;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction : merge

  // bus decode
  wire logic req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic wr      = req && wb_we_i;
  wire logic wr_ctrl = wr && (wb_adr_i == REG_CTRL);
  wire logic wr_sa   = wr && (wb_adr_i == REG_SRC_ADDR);
  wire logic wr_sm   = wr && (wb_adr_i == REG_SRC_MASK);
  wire logic wr_da   = wr && (wb_adr_i == REG_DST_ADDR);
  wire logic wr_dm   = wr && (wb_adr_i == REG_DST_MASK);
  wire logic wr_st   = wr && (wb_adr_i == REG_STATUS);

  // configuration fields
  wire logic [1:0] ft_mode   = ctrl_q[CT_FT +: 2];
  wire logic [2:0] pr_mode   = ctrl_q[CT_PR +: 3];
  wire logic [1:0] ttl_mode  = ctrl_q[CT_TTL +: 2];
  wire logic [1:0] frag_mode = ctrl_q[CT_FRAG +: 2];
  wire logic [1:0] opt_mode  = ctrl_q[CT_OPT +: 2];
  wire logic [1:0] src_mode  = ctrl_q[CT_SRC +: 2];
  wire logic [1:0] dst_mode  = ctrl_q[CT_DST +: 2];
  wire logic [7:0] pr_value  = ctrl_q[CT_PVAL +: 8];

  // protocol criterion
  logic pr_ok;
  always_comb
  begin
    case (pr_mode)
      PR_ANY:  pr_ok = 1'b1;
      PR_SPEC: pr_ok = (frm_proto_i == pr_value);
      PR_ICMP: pr_ok = (frm_proto_i == PROTO_ICMP);
      PR_UDP:  pr_ok = (frm_proto_i == PROTO_UDP);
      PR_TCP:  pr_ok = (frm_proto_i == PROTO_TCP);
      default: pr_ok = 1'b0;
    endcase
  end

  wire logic ttl_pos = (frm_ttl_i != 8'h0);
  wire logic frag    = frm_mf_i || (frm_foff_i != 13'h0);

  logic ttl_ok;
  logic frag_ok;
  logic opt_ok;
  logic src_ok;
  logic dst_ok;

  // no (1) rejects ttl>0, yes (2) accepts only ttl>0, any (0) and 3 accept every ttl
  acm_tri_cmp u_ttl (
    .mode_i (ttl_mode),
    .prop_i (ttl_pos),
    .ok_o   (ttl_ok)
  );

  acm_tri_cmp u_frag (
    .mode_i (frag_mode),
    .prop_i (frag),
    .ok_o   (frag_ok)
  );

  acm_tri_cmp u_opt (
    .mode_i (opt_mode),
    .prop_i (frm_opt_i),
    .ok_o   (opt_ok)
  );

  acm_addr_cmp u_src (
    .mode_i  (src_mode),
    .frame_i (frm_src_i),
    .cfg_i   (src_addr_q),
    .mask_i  (src_mask_q),
    .ok_o    (src_ok)
  );

  acm_addr_cmp u_dst (
    .mode_i  (dst_mode),
    .frame_i (frm_dst_i),
    .cfg_i   (dst_addr_q),
    .mask_i  (dst_mask_q),
    .ok_o    (dst_ok)
  );

  // ip criteria only apply to ipv4 entries; other frame types stay out of scope
  // here, so a non-ipv4 entry never hits from this block
  wire logic ip_entry = (ft_mode == FT_IPV4);
  wire logic all_ok   = ip_entry && frm_ipv4_i && pr_ok && ttl_ok
                        && frag_ok && opt_ok && src_ok && dst_ok;

  // registered result, one cycle after the header strobe
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hit_valid_o <= 1'b0;
      hit_o       <= 1'b0;
    end
    else
    begin
      hit_valid_o <= frm_valid_i;
      hit_o       <= frm_valid_i && all_ok;
    end
  end

  // hit counter saturates; write to status clears it, a hit in that cycle leaves it at 1
  wire logic new_hit = frm_valid_i && all_ok;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      hit_cnt_q <= CNT_RST;
    else if (new_hit)
      hit_cnt_q <= (wr_st || hit_cnt_q == 16'hffff) ? (wr_st ? 16'h1 : hit_cnt_q)
                                                     : hit_cnt_q + 16'h1;
    else if (wr_st)
      hit_cnt_q <= CNT_RST;
  end

  // configuration registers
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_q     <= CTRL_RST;
      src_addr_q <= ADDR_RST;
      src_mask_q <= MASK_RST;
      dst_addr_q <= ADDR_RST;
      dst_mask_q <= MASK_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h00ff_7fff;
      if (wr_sa)
        src_addr_q <= merge(src_addr_q, wb_dat_i, wb_sel_i);
      if (wr_sm)
        src_mask_q <= merge(src_mask_q, wb_dat_i, wb_sel_i);
      if (wr_da)
        dst_addr_q <= merge(dst_addr_q, wb_dat_i, wb_sel_i);
      if (wr_dm)
        dst_mask_q <= merge(dst_mask_q, wb_dat_i, wb_sel_i);
    end
  end

  // read mux; unmapped addresses read zero and still ack
  always_comb
  begin
    case (wb_adr_i)
      REG_CTRL:     rdat_d = ctrl_q;
      REG_SRC_ADDR: rdat_d = src_addr_q;
      REG_SRC_MASK: rdat_d = src_mask_q;
      REG_DST_ADDR: rdat_d = dst_addr_q;
      REG_DST_MASK: rdat_d = dst_mask_q;
      REG_STATUS:   rdat_d = {15'h0, hit_o, hit_cnt_q};
      default:      rdat_d = 32'h0;
    endcase
  end

  assign ack_d = req;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= ack_d;
      wb_dat_o <= (req && !wb_we_i) ? rdat_d : 32'h0;
    end
  end
endmodule : acm_matcher

// ===== src/acm_pkg.sv
package acm_pkg;
  // frame type of the entry
  localparam logic [1:0] FT_ANY  = 2'h0;
  localparam logic [1:0] FT_IPV4 = 2'h1;
  localparam logic [1:0] FT_ARP  = 2'h2;
  localparam logic [1:0] FT_IPV6 = 2'h3;

  // protocol criterion
  localparam logic [2:0] PR_ANY  = 3'h0;
  localparam logic [2:0] PR_SPEC = 3'h1;
  localparam logic [2:0] PR_ICMP = 3'h2;
  localparam logic [2:0] PR_UDP  = 3'h3;
  localparam logic [2:0] PR_TCP  = 3'h4;

  localparam logic [7:0] PROTO_ICMP = 8'h01;
  localparam logic [7:0] PROTO_UDP  = 8'h11;
  localparam logic [7:0] PROTO_TCP  = 8'h06;

  // tri-state criteria (ttl, fragment, options): any / no(zero) / yes(non-zero)
  localparam logic [1:0] TS_ANY = 2'h0;
  localparam logic [1:0] TS_NO  = 2'h1;
  localparam logic [1:0] TS_YES = 2'h2;

  // address filter
  localparam logic [1:0] AF_ANY  = 2'h0;
  localparam logic [1:0] AF_HOST = 2'h1;
  localparam logic [1:0] AF_NET  = 2'h2;

  // register map, byte addresses
  localparam logic [4:0] REG_CTRL     = 5'h00;
  localparam logic [4:0] REG_SRC_ADDR = 5'h04;
  localparam logic [4:0] REG_SRC_MASK = 5'h08;
  localparam logic [4:0] REG_DST_ADDR = 5'h0c;
  localparam logic [4:0] REG_DST_MASK = 5'h10;
  localparam logic [4:0] REG_STATUS   = 5'h14;

  // ctrl field positions
  localparam int CT_FT   = 0;
  localparam int CT_PR   = 2;
  localparam int CT_TTL  = 5;
  localparam int CT_FRAG = 7;
  localparam int CT_OPT  = 9;
  localparam int CT_SRC  = 11;
  localparam int CT_DST  = 13;
  localparam int CT_PVAL = 16;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'hffff_ffff;
  localparam logic [15:0] CNT_RST  = 16'h0000;
endpackage : acm_pkg

// ===== src/acm_addr_cmp.sv
`timescale 1ns/1ps
// compares one address against a filter in host or network mode
module acm_addr_cmp
  import acm_pkg::*;
(
  input  wire logic [1:0]  mode_i,   // filter mode
  input  wire logic [31:0] frame_i,  // address from frame
  input  wire logic [31:0] cfg_i,    // configured address
  input  wire logic [31:0] mask_i,   // configured mask
  output logic             ok_o      // criterion met
);
  wire logic [31:0] diff = frame_i ^ cfg_i;

  always_comb
  begin
    case (mode_i)
      AF_HOST: ok_o = (diff == 32'h0);
      AF_NET:  ok_o = ((diff & mask_i) == 32'h0);
      default: ok_o = 1'b1;
    endcase
  end
endmodule : acm_addr_cmp

// ===== src/acm_tri_cmp.sv
`timescale 1ns/1ps
// any / no / yes criterion against a boolean frame property
module acm_tri_cmp
  import acm_pkg::*;
(
  input  wire logic [1:0] mode_i,  // criterion setting
  input  wire logic       prop_i,  // frame property
  output logic            ok_o     // criterion met
);
  always_comb
  begin
    case (mode_i)
      TS_NO:   ok_o = !prop_i;
      TS_YES:  ok_o = prop_i;
      default: ok_o = 1'b1;
    endcase
  end
endmodule : acm_tri_cmp

// ===== tb/acm_assertions.sv
`timescale 1ns/1ps
module acm_assertions (
  input wire logic        clk_i,       // clock
  input wire logic        rst_i,       // reset
  input wire logic        wb_cyc_i,    // cycle
  input wire logic        wb_stb_i,    // strobe
  input wire logic        wb_ack_o,    // ack
  input wire logic [31:0] wb_dat_o,    // read data
  input wire logic        frm_valid_i, // header strobe
  input wire logic        frm_ipv4_i,  // ipv4 frame
  input wire logic        hit_valid_o, // result strobe
  input wire logic        hit_o        // hit
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  hit_lat_a: assert property (frm_valid_i |=> hit_valid_o)
    else $error("result missing");
  hit_cause_a: assert property (hit_valid_o |-> $past(frm_valid_i))
    else $error("stray result");
  hit_gate_a: assert property (hit_o |-> hit_valid_o)
    else $error("hit without strobe");
  ipv4_only_a: assert property (frm_valid_i && !frm_ipv4_i |=> !hit_o)
    else $error("hit on non ipv4");
endmodule : acm_assertions
bind acm_matcher acm_assertions chk_u (.*);

// ===== tb/acm_parser_model.sv
`timescale 1ns/1ps
module acm_parser_model (
  input  wire logic clk_i,  // clock
  output logic      v_o,    // header strobe
  output logic [95:0] f_o   // ipv4,proto,ttl,mf,offset,opt,src,dst
);
  // outside a strobe the fields churn, so stale values never look valid
  task automatic junk();
    f_o <= {$urandom, $urandom, $urandom};
  endtask : junk
  task automatic send(input logic [95:0] f);
    @(posedge clk_i);
    v_o <= 1'b1;
    f_o <= f;
  endtask : send
  task automatic rest();
    @(posedge clk_i);
    v_o <= 1'b0;
    junk();
  endtask : rest
  initial
  begin
    v_o <= 1'b0;
    junk();
  end
endmodule : acm_parser_model

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
  import acm_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fv, hit_valid_o, hit_o;
  logic [4:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, ctl, sa, sm, da, dm, r;
  logic [95:0] ff, g;
  logic [31:0] rd_q[$];
  logic        hit_q[$];
  int          n_fail, comparisons, n_hits;
  acm_parser_model par_u (.clk_i(clk_i), .v_o(fv), .f_o(ff));
  acm_matcher dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frm_valid_i(fv), .frm_ipv4_i(ff[95]),
    .frm_proto_i(ff[94:87]), .frm_ttl_i(ff[86:79]), .frm_mf_i(ff[78]), .frm_foff_i(ff[77:65]),
    .frm_opt_i(ff[64]), .frm_src_i(ff[63:32]), .frm_dst_i(ff[31:0]),
    .hit_valid_o(hit_valid_o), .hit_o(hit_o));
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic tally_and_finish();
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, d, 4'hf};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      n_fail++;
      tally_and_finish();
    end
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : wb
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd
  function automatic logic tri_ok(logic [1:0] m, logic p);
    return m == TS_NO ? !p : m == TS_YES ? p : 1'b1;
  endfunction : tri_ok
  function automatic logic adr_ok(logic [1:0] m, logic [31:0] f, logic [31:0] c, logic [31:0] k);
    return m == AF_HOST ? f == c : m == AF_NET ? ((f ^ c) & k) == 32'h0 : 1'b1;
  endfunction : adr_ok
  function automatic logic ref_hit(logic [95:0] f);
    logic [2:0] pm;
    logic       ok;
    pm = ctl[4:2];
    ok = ctl[1:0] == FT_IPV4 && f[95];
    if (pm == PR_SPEC) ok &= f[94:87] == ctl[23:16];
    else if (pm == PR_ICMP) ok &= f[94:87] == 8'd1;
    else if (pm == PR_UDP) ok &= f[94:87] == 8'd17;
    else if (pm == PR_TCP) ok &= f[94:87] == 8'd6;
    else if (pm != PR_ANY) ok = 1'b0;
    ok &= tri_ok(ctl[6:5], f[86:79] != 8'h0);
    ok &= tri_ok(ctl[8:7], f[78] || f[77:65] != 13'h0);
    ok &= tri_ok(ctl[10:9], f[64]);
    ok &= adr_ok(ctl[12:11], f[63:32], sa, sm);
    ok &= adr_ok(ctl[14:13], f[31:0], da, dm);
    return ok;
  endfunction : ref_hit
  always @(posedge clk_i)
  begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check("rdata", wb_dat_o, rd_q.pop_front());
    // a result with no note behind it is a stray strobe, not a silent pass
    if (hit_valid_o === 1'b1 && hit_q.size() == 0) check("hit_extra", 32'h1, 32'h0);
    else if (hit_valid_o === 1'b1) check("hit", {31'h0, hit_o}, {31'h0, hit_q.pop_front()});
  end
  initial
  begin
    void'($urandom(32));
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {4'h8, 41'h0};
    {ctl, sa, sm, da, dm} = {CTRL_RST, ADDR_RST, MASK_RST, ADDR_RST, MASK_RST};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(REG_CTRL, CTRL_RST);
    rd(REG_SRC_MASK, MASK_RST);
    rd(REG_DST_ADDR, ADDR_RST);
    rd(REG_STATUS, {16'h0, CNT_RST});
    wb(1'b1, 5'h18, 32'hffff_ffff);
    rd(5'h18, 32'h0);
    for (int i = 0; i < 800; i++)
    begin
      if (i % 4 == 0 && i > 0)
      begin
        {ctl, sa, sm, da, dm} = {$urandom, $urandom, $urandom, $urandom, $urandom};
        if (ctl[25]) ctl[1:0] = FT_IPV4;
        wb(1'b1, REG_CTRL, ctl);
        wb(1'b1, REG_SRC_ADDR, sa);
        wb(1'b1, REG_SRC_MASK, sm);
        wb(1'b1, REG_DST_ADDR, da);
        wb(1'b1, REG_DST_MASK, dm);
        ctl &= 32'h00ff_7fff;
        rd(REG_CTRL, ctl);
      end
      r = $urandom;
      g = {$urandom, $urandom, $urandom};
      g[95] = r[8] | r[9];
      g[94:87] = r[0] ? ctl[23:16] : r[1] ? (r[2] ? 8'd1 : 8'd17) : (r[2] ? 8'd6 : g[94:87]);
      g[86:79] = r[3] ? 8'h0 : r[4] ? 8'h1 : g[86:79];
      g[77:65] = r[6] ? 13'h0 : r[7] ? 13'h1 : g[77:65];
      g[63:32] = r[10] ? sa ^ (~sm & (r[11] ? 32'h0 : g[63:32])) : g[63:32];
      g[31:0] = r[12] ? da ^ (~dm & (r[13] ? 32'h0 : g[31:0])) : g[31:0];
      hit_q.push_back(ref_hit(g));
      if (hit_q[$]) n_hits++;
      par_u.send(g);
      if (i % 4 == 3) par_u.rest();
    end
    repeat (3) @(posedge clk_i);
    // count of hits seen, last result low after the idle gap
    rd(REG_STATUS, {16'h0, 16'(n_hits)});
    wb(1'b1, REG_STATUS, 32'h0);
    rd(REG_STATUS, 32'h0);
    repeat (3) @(posedge clk_i);
    check("pending", 32'(hit_q.size() + rd_q.size()), 32'h0);
    tally_and_finish();
  end
endmodule : tb
